// [src/ppd_detector.sv]
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`default_nettype none
module ppd_detector #(
   parameter int unsigned TICK_CYC = ppd_pkg::TICK_CYC
) (
   input  wire logic        ref_clk_i,     // 200 MHz clock
   input  wire logic        reset_n_i,     // sync reset, active low
   input  wire logic        clk_en_i,      // freezes all state when low
   input  wire logic        off_hook_i,    // line is held off hook
   input  wire logic        ctr21_mode_i,  // current-limiting termination
   input  wire logic        sense_valid_i, // new converter sample
   input  wire logic [9:0]  sense_raw_i,   // sample, quarter-code units
   output ppd_pkg::ppd_evt_s result_o,     // result code strobe
   input  wire logic        awvalid,       // axi write address
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,        // axi write data
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,        // axi write response
   input  wire logic        bready,
   output logic [1:0]       bresp,
   input  wire logic        arvalid,       // axi read address
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,        // axi read data
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   ppd_pkg::ppd_state_e st_q;
   logic [7:0]  cur_q;
   logic [7:0]  onh_thr_q;
   logic [7:0]  ofh_thr_q;
   logic [6:0]  dgrate_q;
   logic [1:0]  method_q;
   logic        mask_q;
   logic [3:0]  settle_q;
   logic        alt_q;
   logic [3:0]  code_en_q;
   logic        intr_q;
   logic        lost_q;
   logic [7:0]  hist_q [ppd_pkg::DIFF1_DEPTH];
   logic [7:0]  dg_prev_q;
   logic [7:0]  last_good_q;
   logic [15:0] tk_cnt_q;
   logic [15:0] per_cnt_q;
   logic [6:0]  unit_cnt_q;
   logic [19:0] settle_cnt_q;
   logic        aw_hold_q;
   logic        w_hold_q;
   logic [7:0]  aw_addr_q;
   logic [7:0]  w_data_q;
   logic        w_lane_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   ppd_pkg::ppd_evt_s evt_q;

   // ----------------------------------------
   // timebase and periods
   // ----------------------------------------
   logic tick;
   logic per_hit;
   logic step;
   logic use_diff2;
   logic settle_done;
   logic [6:0] step_units;

   assign tick      = (tk_cnt_q == 16'(TICK_CYC - 1));
   assign use_diff2 = method_q[1] && (dgrate_q != 7'h00);
   assign step_units = use_diff2 ? dgrate_q : 7'(ppd_pkg::DIFF1_UNITS);
   assign per_hit   = tick && (st_q == ppd_pkg::ST_ON ?
                      per_cnt_q == 16'(ppd_pkg::ONH_PERIOD_TK - 1) :
                      per_cnt_q == 16'(ppd_pkg::DG_UNIT_TK - 1));
   assign step      = (st_q == ppd_pkg::ST_ON) ? per_hit :
                      (per_hit && unit_cnt_q == step_units - 7'h01);
   assign settle_done = tick && (settle_cnt_q >=
                        20'(settle_q * ppd_pkg::SETTLE_UNIT_TK));

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         tk_cnt_q <= 16'h0000;
      end else if (clk_en_i) begin
         tk_cnt_q <= tick ? 16'h0000 : tk_cnt_q + 16'h0001;
      end
   end

   ppd_pkg::ppd_state_e st_d;
   always_comb begin
      st_d = st_q;
      case (st_q)
         ppd_pkg::ST_ON:     if (off_hook_i) st_d = ppd_pkg::ST_SETTLE;
         ppd_pkg::ST_SETTLE: if (!off_hook_i) st_d = ppd_pkg::ST_ON;
                             else if (settle_done) st_d = ppd_pkg::ST_OFF;
         ppd_pkg::ST_OFF:    if (!off_hook_i) st_d = ppd_pkg::ST_ON;
         default:            st_d = ppd_pkg::ST_ON;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         st_q         <= ppd_pkg::ST_ON;
         per_cnt_q    <= 16'h0000;
         unit_cnt_q   <= 7'h00;
         settle_cnt_q <= 20'h00000;
      end else if (clk_en_i) begin
         st_q <= st_d;
         if (st_d != st_q) begin
            per_cnt_q    <= 16'h0000;
            unit_cnt_q   <= 7'h00;
            settle_cnt_q <= 20'h00000;
         end else if (tick) begin
            per_cnt_q    <= per_hit ? 16'h0000 : per_cnt_q + 16'h0001;
            settle_cnt_q <= settle_cnt_q + 20'h00001;
            if (per_hit) begin
               unit_cnt_q <= step ? 7'h00 : unit_cnt_q + 7'h01;
            end
         end
      end
   end

   // ----------------------------------------
   // sense value with current hysteresis
   // ----------------------------------------
   logic [10:0] base_q4;
   logic [10:0] raw_w;
   logic [10:0] hyst;
   logic        accept;

   assign base_q4 = {1'b0, cur_q, 2'b00};
   assign raw_w   = {1'b0, sense_raw_i};
   assign hyst    = ctr21_mode_i ? 11'(ppd_pkg::HYST_LIM_Q) : 11'(ppd_pkg::HYST_STD_Q);
   assign accept  = (st_q == ppd_pkg::ST_ON) ||
                    (raw_w >= base_q4 + 11'h004 + hyst) ||
                    (raw_w + hyst < base_q4);

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         cur_q <= 8'h00;
      end else if (clk_en_i && sense_valid_i && accept) begin
         cur_q <= sense_raw_i[9:2];
      end
   end

   // ----------------------------------------
   // intrusion decision
   // ----------------------------------------
   logic [7:0] old_s;
   logic [2:0] dthr;
   logic       drop;
   logic       rise;
   logic       intr_set;
   logic       intr_clr;
   logic       run_on;
   logic       dg_ok;

   assign run_on = (st_q == ppd_pkg::ST_ON) && !alt_q;
   assign dg_ok  = (cur_q == dg_prev_q);
   assign dthr   = (st_q == ppd_pkg::ST_ON) ? onh_thr_q[7:5] : ofh_thr_q[7:5];
   always_comb begin
      old_s = hist_q[0];
      if (st_q != ppd_pkg::ST_ON) begin
         old_s = use_diff2 ? hist_q[ppd_pkg::DIFF2_DEPTH - 1]
                           : hist_q[ppd_pkg::DIFF1_DEPTH - 1];
      end
   end
   assign drop = {1'b0, old_s} > {1'b0, cur_q} + {6'h00, dthr};
   assign rise = {1'b0, cur_q} > {1'b0, old_s} + {6'h00, dthr};

   always_comb begin
      intr_set = 1'b0;
      intr_clr = 1'b0;
      if (run_on) begin
         if (!method_q[0]) begin
            intr_set = cur_q < {3'h0, onh_thr_q[4:0]};
            intr_clr = !intr_set;
         end else if (step) begin
            intr_set = drop;
            intr_clr = rise;
         end
      end else if (st_q == ppd_pkg::ST_OFF) begin
         if (!method_q[1]) begin
            intr_set = cur_q < {3'h0, ofh_thr_q[4:0]};
            intr_clr = !intr_set;
         end else if (step && (!use_diff2 || dg_ok)) begin
            intr_set = drop;
            intr_clr = rise;
         end
      end
   end

   // history buffer, preloaded on entry to off hook from the reference, or from the sense value when the reference is 0
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < ppd_pkg::DIFF1_DEPTH; i++) hist_q[i] <= 8'h00;
         dg_prev_q <= 8'h00;
      end else if (clk_en_i) begin
         if (st_d == ppd_pkg::ST_OFF && st_q != ppd_pkg::ST_OFF) begin
            for (int i = 0; i < ppd_pkg::DIFF1_DEPTH; i++) begin
               hist_q[i] <= (ofh_thr_q[4:0] != 5'h00) ? {3'h0, ofh_thr_q[4:0]} : cur_q;
            end
            dg_prev_q <= cur_q;
         end else if (step) begin
            dg_prev_q <= cur_q;
            if (st_q == ppd_pkg::ST_ON || !use_diff2 || dg_ok) begin
               hist_q[0] <= cur_q;
               for (int i = 1; i < ppd_pkg::DIFF1_DEPTH; i++) hist_q[i] <= hist_q[i-1];
            end
         end
      end
   end

   // ----------------------------------------
   // status, result codes, reference
   // ----------------------------------------
   logic       intr_d;
   logic       lost_d;
   logic       evt_ok;
   ppd_pkg::ppd_code_e evt_code;
   logic       evt_fire;

   assign intr_d = intr_set ? 1'b1 : (intr_clr ? 1'b0 : intr_q);
   assign lost_d = run_on ? (cur_q == 8'h00) : lost_q;
   always_comb begin
      evt_fire = 1'b1;
      evt_code = ppd_pkg::CODE_INTR_START;
      if (lost_d != lost_q) begin
         evt_code = lost_d ? ppd_pkg::CODE_LINE_LOST : ppd_pkg::CODE_LINE_BACK;
      end else if (intr_d != intr_q) begin
         evt_code = intr_d ? ppd_pkg::CODE_INTR_START : ppd_pkg::CODE_INTR_END;
      end else begin
         evt_fire = 1'b0;
      end
   end
   assign evt_ok = !alt_q && (!mask_q || code_en_q[evt_code]);

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         intr_q <= 1'b0;
         lost_q <= 1'b0;
         evt_q  <= '0;
      end else if (clk_en_i) begin
         intr_q      <= intr_d;
         lost_q      <= lost_d;
         evt_q.valid <= evt_fire && evt_ok;
         evt_q.code  <= evt_code;
      end
   end
   assign result_o = evt_q;

   logic [4:0] ref_sat;
   assign ref_sat = (last_good_q[7:5] != 3'h0) ? 5'h1f : last_good_q[4:0];

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         last_good_q <= 8'h00;
      end else if (clk_en_i) begin
         if (st_q != ppd_pkg::ST_OFF && st_d == ppd_pkg::ST_OFF) begin
            last_good_q <= (ofh_thr_q[4:0] != 5'h00) ? {3'h0, ofh_thr_q[4:0]} : cur_q;
         // absolute mode decides on every sample, differential only at a step
         end else if (st_q == ppd_pkg::ST_OFF && (step || !method_q[1])
                      && !intr_q && !intr_set) begin
            last_good_q <= cur_q;
         end
      end
   end

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   logic do_wr;
   logic do_rd;
   logic wr_hit;
   logic rd_hit;
   logic [7:0] rd_val;

   assign awready = clk_en_i && !aw_hold_q && !bvalid_q;
   assign wready  = clk_en_i && !w_hold_q && !bvalid_q;
   assign arready = clk_en_i && !rvalid_q;
   assign do_wr   = aw_hold_q && w_hold_q && !bvalid_q && clk_en_i;
   assign do_rd   = arvalid && arready && clk_en_i;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'b00) && (a <= ppd_pkg::OFS_CODE_EN);
   endfunction
   assign wr_hit = mapped(aw_addr_q);
   assign rd_hit = mapped(araddr);

   always_comb begin
      case (araddr)
         ppd_pkg::OFS_SENSE:   rd_val = cur_q;
         ppd_pkg::OFS_ONH_THR: rd_val = onh_thr_q;
         ppd_pkg::OFS_OFH_THR: rd_val = ofh_thr_q;
         ppd_pkg::OFS_DGRATE:  rd_val = {1'b0, dgrate_q};
         ppd_pkg::OFS_METHOD:  rd_val = {3'h0, method_q, 3'h0};
         ppd_pkg::OFS_STATUS:  rd_val = {mask_q, 4'h0, lost_q, intr_q, 1'b0};
         ppd_pkg::OFS_SETTLE:  rd_val = {settle_q, 4'h0};
         ppd_pkg::OFS_SUPPR:   rd_val = {1'b0, alt_q, 6'h00};
         ppd_pkg::OFS_CODE_EN: rd_val = {4'h0, code_en_q};
         default:              rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 8'h00;
         w_lane_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= ppd_pkg::RESP_OKAY;
      end else if (clk_en_i) begin
         if (awvalid && awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= wdata[7:0];
            w_lane_q <= wstrb[0];
         end
         if (do_wr) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_hit ? ppd_pkg::RESP_OKAY : ppd_pkg::RESP_SLVERR;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= ppd_pkg::RESP_OKAY;
      end else if (clk_en_i) begin
         if (do_rd) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_val};
            rresp_q  <= rd_hit ? ppd_pkg::RESP_OKAY : ppd_pkg::RESP_SLVERR;
         end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end
   assign bvalid = bvalid_q;
   assign bresp  = bresp_q;
   assign rvalid = rvalid_q;
   assign rdata  = rdata_q;
   assign rresp  = rresp_q;

   // ----------------------------------------
   // configuration writes
   // ----------------------------------------
   logic wr_en;
   logic ref_clr;
   logic ref_load;
   assign wr_en    = do_wr && w_lane_q;
   assign ref_load = (st_q == ppd_pkg::ST_OFF) && (st_d == ppd_pkg::ST_ON);
   assign ref_clr  = (st_q == ppd_pkg::ST_ON) && lost_q && !lost_d;

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         onh_thr_q <= ppd_pkg::RST_ONH_THR;
         dgrate_q  <= ppd_pkg::RST_DGRATE;
         method_q  <= ppd_pkg::RST_METHOD;
         mask_q    <= 1'b0;
         settle_q  <= ppd_pkg::RST_SETTLE;
         alt_q     <= 1'b0;
         code_en_q <= ppd_pkg::RST_CODE_EN;
      end else if (wr_en) begin
         case (aw_addr_q)
            ppd_pkg::OFS_ONH_THR: onh_thr_q <= w_data_q;
            ppd_pkg::OFS_DGRATE:  dgrate_q  <= w_data_q[6:0];
            ppd_pkg::OFS_METHOD:  method_q  <= w_data_q[4:3];
            ppd_pkg::OFS_STATUS:  mask_q    <= w_data_q[ppd_pkg::BIT_MASK];
            ppd_pkg::OFS_SETTLE:  settle_q  <= w_data_q[7:4];
            ppd_pkg::OFS_SUPPR:   alt_q     <= w_data_q[ppd_pkg::BIT_ALT];
            ppd_pkg::OFS_CODE_EN: code_en_q <= w_data_q[3:0];
            default:              mask_q    <= mask_q;
         endcase
      end
   end

   // hardware reference updates win over a software write
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         ofh_thr_q <= ppd_pkg::RST_OFH_THR;
      end else if (clk_en_i) begin
         if (ref_clr) begin
            ofh_thr_q[4:0] <= 5'h00;
         end else if (ref_load) begin
            ofh_thr_q[4:0] <= ref_sat;
         end else if (wr_en && aw_addr_q == ppd_pkg::OFS_OFH_THR) begin
            ofh_thr_q <= w_data_q;
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i || !clk_en_i);

   sequence s_leave_off;
      st_q == ppd_pkg::ST_OFF ##1 st_q == ppd_pkg::ST_ON;
   endsequence
   sequence s_enter_off;
      st_q == ppd_pkg::ST_SETTLE ##1 st_q == ppd_pkg::ST_OFF;
   endsequence

   chk_avl_reset_val: assert property ($rose(reset_n_i) |-> onh_thr_q == 8'h48)
      else $error("on-hook threshold reset value wrong");
   chk_abs_onhook_trip: assert property (run_on && !method_q[0]
      && cur_q < {3'h0, onh_thr_q[4:0]} |=> intr_q)
      else $error("absolute on-hook intrusion missed");
   chk_start_code_out: assert property (!intr_q && intr_d && !alt_q && !mask_q
      && lost_d == lost_q |=> result_o.valid && result_o.code == ppd_pkg::CODE_INTR_START)
      else $error("intrusion start code missing");
   chk_line_lost_flag: assert property (run_on && cur_q == 8'h00 |=> lost_q)
      else $error("line-lost status not set");
   chk_mask_keeps_status: assert property (mask_q && code_en_q == 4'h0
      && intr_d != intr_q |=> !result_o.valid && intr_q == $past(intr_d))
      else $error("mask broke status or leaked code");
   chk_alt_freeze_status: assert property (alt_q && st_q == ppd_pkg::ST_ON
      |=> $stable(intr_q) && $stable(lost_q) && !result_o.valid)
      else $error("alternate suppress did not freeze");
   chk_settle_wait_done: assert property (s_enter_off |-> $past(settle_cnt_q) >=
      20'($past(settle_q) * ppd_pkg::SETTLE_UNIT_TK))
      else $error("off-hook algorithm enabled before settle");
   chk_ref_on_hook_load: assert property (s_leave_off ##0 !$past(ref_clr)
      |-> ofh_thr_q[4:0] == $past(ref_sat))
      else $error("reference not saved on hook");
   chk_abs_offhook_trip: assert property (st_q == ppd_pkg::ST_OFF && !method_q[1]
      && off_hook_i && cur_q < {3'h0, ofh_thr_q[4:0]} |=> intr_q)
      else $error("absolute off-hook intrusion missed");
endmodule : ppd_detector
`default_nettype wire

// [src/ppd_pkg.sv]
`default_nettype none
package ppd_pkg;
   // sense code scale
   localparam int unsigned FULL_SCALE_MV  = 87000;
   localparam int unsigned CODE_STEP_MV   = 2750;
   localparam int unsigned ZERO_BELOW_MV  = 3000;
   // timing
   localparam int unsigned CLK_PERIOD_NS  = 5;
   localparam int unsigned TICK_NS        = 10000;
   localparam int unsigned TICK_CYC       = TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned ONH_PERIOD_US  = 26660;
   localparam int unsigned ONH_PERIOD_TK  = ONH_PERIOD_US * 1000 / TICK_NS;
   localparam int unsigned DG_UNIT_MS     = 40;
   localparam int unsigned DG_UNIT_TK     = DG_UNIT_MS * 1000000 / TICK_NS;
   localparam int unsigned DIFF1_STEP_MS  = 200;
   localparam int unsigned DIFF1_SPAN_MS  = 800;
   localparam int unsigned DIFF1_UNITS    = DIFF1_STEP_MS / DG_UNIT_MS;
   localparam int unsigned DIFF1_DEPTH    = DIFF1_SPAN_MS / DIFF1_STEP_MS;
   localparam int unsigned DIFF2_SPAN_MS  = 80;
   localparam int unsigned DIFF2_DEPTH    = DIFF2_SPAN_MS / DG_UNIT_MS;
   localparam int unsigned SETTLE_UNIT_MS = 250;
   localparam int unsigned SETTLE_UNIT_TK = SETTLE_UNIT_MS * 1000000 / TICK_NS;
   // current hysteresis in quarter-code steps
   localparam int unsigned CUR_STEP_UA    = 1500;
   localparam int unsigned HYST_LIM_UA    = 375;
   localparam int unsigned HYST_STD_UA    = 750;
   localparam int unsigned HYST_LIM_Q     = HYST_LIM_UA * 4 / CUR_STEP_UA;
   localparam int unsigned HYST_STD_Q     = HYST_STD_UA * 4 / CUR_STEP_UA;
   // register byte offsets
   localparam logic [7:0] OFS_SENSE   = 8'h00;
   localparam logic [7:0] OFS_ONH_THR = 8'h04;
   localparam logic [7:0] OFS_OFH_THR = 8'h08;
   localparam logic [7:0] OFS_DGRATE  = 8'h0c;
   localparam logic [7:0] OFS_METHOD  = 8'h10;
   localparam logic [7:0] OFS_STATUS  = 8'h14;
   localparam logic [7:0] OFS_SETTLE  = 8'h18;
   localparam logic [7:0] OFS_SUPPR   = 8'h1c;
   localparam logic [7:0] OFS_CODE_EN = 8'h20;
   // field positions
   localparam int unsigned BIT_ONH_METHOD = 3;
   localparam int unsigned BIT_OFH_METHOD = 4;
   localparam int unsigned BIT_INTR       = 1;
   localparam int unsigned BIT_LOST       = 2;
   localparam int unsigned BIT_MASK       = 7;
   localparam int unsigned BIT_ALT        = 6;
   // reset values
   localparam logic [7:0] RST_ONH_THR = 8'h48;
   localparam logic [7:0] RST_OFH_THR = 8'h40;
   localparam logic [6:0] RST_DGRATE  = 7'h00;
   localparam logic [1:0] RST_METHOD  = 2'h2;
   localparam logic [3:0] RST_SETTLE  = 4'h4;
   localparam logic [3:0] RST_CODE_EN = 4'h0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_ON     = 3'h1,
      ST_SETTLE = 3'h2,
      ST_OFF    = 3'h4
   } ppd_state_e;

   typedef enum logic [1:0] {
      CODE_INTR_START = 2'h0,
      CODE_INTR_END   = 2'h1,
      CODE_LINE_LOST  = 2'h2,
      CODE_LINE_BACK  = 2'h3
   } ppd_code_e;

   typedef struct packed {
      logic      valid;
      ppd_code_e code;
   } ppd_evt_s;
endpackage : ppd_pkg
`default_nettype wire

// [tb/parallel_phone_intrusion_detector_bench.sv]
`default_nettype none
module parallel_phone_intrusion_detector_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 0, reset_n_i = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic rready = 0, req = 0, oh = 0, lim = 0, awready, wready, bvalid, arready, rvalid, sv;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp, r, last_code;
   logic [9:0] val = 10'h000, raw;
   ppd_pkg::ppd_evt_s result_o;
   int bad_count = 0, num_checks = 0, evt_n = 0, cyc = 0, e0 = 0;
   initial forever #2.5 ref_clk_i = ~ref_clk_i;
   ppd_sense_model sm_u (.clk_i(ref_clk_i), .req_i(req), .val_i(val), .sense_valid_o(sv),
      .sense_raw_o(raw));
   ppd_detector #(.TICK_CYC(2)) dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .clk_en_i(1'b1), .off_hook_i(oh), .ctr21_mode_i(lim), .sense_valid_i(sv),
      .sense_raw_i(raw), .result_o(result_o), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
   always @(posedge ref_clk_i) begin
      if (result_o.valid === 1'b1) begin
         evt_n++;
         last_code = result_o.code;
      end
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk_i);
      awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= v; bready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk_i);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata; r = rresp;
      rready <= 1'b0;
   endtask
   task automatic snd(input logic [9:0] v);
      @(posedge ref_clk_i);
      req <= 1'b1; val <= v;
      @(posedge ref_clk_i);
      req <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      rd(8'h04); chk(d, 32'h48, "onh_thr");
      rd(8'h18); chk(d, 32'h40, "settle");
      rd(8'h10); chk(d, 32'h10, "method");
      rd(8'h24); chk(r, ppd_pkg::RESP_SLVERR, "unmapped");
      $display("test regs done");
      // settle the line first, count events from here on
      snd(10'h024); e0 = evt_n;
      // code 8 equals threshold: no intrusion
      snd(10'h020); chk(evt_n - e0, 0, "no_evt");
      rd(8'h00); chk(d, 32'h08, "sense");
      snd(10'h01c); chk(last_code, ppd_pkg::CODE_INTR_START, "start");
      rd(8'h14); chk(d, 32'h02, "intr_set");
      snd(10'h024); chk(last_code, ppd_pkg::CODE_INTR_END, "end");
      rd(8'h14); chk(d, 32'h00, "intr_clr");
      $display("test absolute done");
      snd(10'h000); chk(last_code, ppd_pkg::CODE_LINE_LOST, "lost");
      rd(8'h14); chk(d, 32'h06, "lost_set");
      snd(10'h024); chk(last_code, ppd_pkg::CODE_LINE_BACK, "back");
      chk(evt_n - e0, 4, "evt_cnt");
      $display("test line done");
      wr(8'h14, 32'h80);
      snd(10'h01c); chk(evt_n - e0, 4, "masked");
      rd(8'h14); chk(d, 32'h82, "mask_stat");
      snd(10'h024); rd(8'h14); chk(d, 32'h80, "mask_end");
      wr(8'h1c, 32'h40);
      snd(10'h01c); rd(8'h14); chk(d, 32'h80, "alt_stat");
      chk(evt_n - e0, 4, "alt_evt");
      $display("test suppress done");
      snd(10'h024); wr(8'h1c, 32'h00); wr(8'h14, 32'h00);
      wr(8'h10, 32'h00); wr(8'h18, 32'h00);
      wr(8'h0c, 32'h19);
      wr(8'h08, 32'h40);
      oh <= 1'b1;
      snd(10'h030); rd(8'h00); chk(d, 32'h0c, "cur_code");
      snd(10'h02e); rd(8'h00); chk(d, 32'h0c, "hyst_std");
      lim <= 1'b1;
      snd(10'h02e); rd(8'h00); chk(d, 32'h0b, "hyst_lim");
      oh <= 1'b0;
      snd(10'h02e); rd(8'h08); chk(d, 32'h4b, "ref_saved");
      oh <= 1'b1;
      snd(10'h010); chk(last_code, ppd_pkg::CODE_INTR_START, "off_start");
      rd(8'h14); chk(d, 32'h02, "off_intr");
      snd(10'h030); chk(last_code, ppd_pkg::CODE_INTR_END, "off_end");
      oh <= 1'b0;
      snd(10'h000); snd(10'h024); rd(8'h08); chk(d, 32'h40, "ref_clear");
      $display("test offhook done");
      wr(8'h10, 32'h08);
      repeat (5400) @(posedge ref_clk_i);
      snd(10'h014); repeat (5400) @(posedge ref_clk_i);
      chk(last_code, ppd_pkg::CODE_INTR_START, "diff_start");
      snd(10'h024); repeat (5400) @(posedge ref_clk_i);
      chk(last_code, ppd_pkg::CODE_INTR_END, "diff_end");
      $display("test differential done");
      test_done();
   end
endmodule // parallel_phone_intrusion_detector_bench
`default_nettype wire

// [tb/ppd_sense_model.sv]
`default_nettype none
module ppd_sense_model (
   input  wire logic       clk_i,         // bench clock
   input  wire logic       req_i,         // take one conversion
   input  wire logic [9:0] val_i,         // level to report
   output logic            sense_valid_o, // sample strobe
   output logic [9:0]      sense_raw_o    // sample value
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sense_valid_o = 1'b0;
      sense_raw_o   = 10'h000;
   end
   // data only meaningful with the strobe, otherwise keeps changing
   always @(posedge clk_i) begin
      sense_valid_o <= req_i;
      sense_raw_o   <= req_i ? val_i : ~sense_raw_o;
   end
endmodule // ppd_sense_model
`default_nettype wire
